// *** lpp_pkg.sv ***
package lpp_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_CFG      = 8'h04;
	localparam logic [7:0] ADDR_SEG_BASE = 8'h08;
	localparam int         SEG_REGS      = 4;
	// Control register field positions
	localparam int BIT_WAVE_KIND   = 7;
	localparam int BIT_BIAS_LEVEL  = 6;
	localparam int BIT_DRV_ACTIVE  = 5;
	localparam int BIT_SEG_PERMIT  = 4;
	localparam int PRESC_LSB       = 0;
	localparam int PRESC_W         = 4;
	// Configuration register field positions
	localparam int BIT_DRV_ENABLE  = 0;
	localparam int MUX_LSB         = 1;
	localparam int MUX_W           = 2;
	// Values after reset
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_CFG  = 8'h00;
	localparam logic [7:0] RST_SEG  = 8'h00;
	// Multiplex encodings
	localparam logic [1:0] MUX_STATIC = 2'h0;
	localparam logic [1:0] MUX_QUAD   = 2'h3;
	// Drive state towards the analog and segment logic
	typedef struct packed {
		logic       type_b;      // Frame-boundary phase waveform selected
		logic       phase;       // Current drive phase
		logic [1:0] com_index;   // Common being driven
		logic       bias_static; // Static bias in use
		logic       bias_half;   // One-half bias in use
	} lpp_drive_t;
	localparam lpp_drive_t RST_DRIVE = '0;
endpackage

// *** lpp_core.sv ***
module lpp_core (
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Drive outputs
	output lpp_pkg::lpp_drive_t       drive,
	output logic                      lcd_tick,
	output logic                      frame_end,
	output logic      [31:0]          segment_pattern_regs
);
	// Software state
	logic [7:0]          ctrl_ff, nxt_ctrl;       // Wave, bias, prescale
	logic [7:0]          cfg_ff, nxt_cfg;         // Enable and multiplex
	logic [7:0]          seg_ff [lpp_pkg::SEG_REGS];
	logic [7:0]          nxt_seg [lpp_pkg::SEG_REGS];
	// Engine state
	logic                active_ff, nxt_active;   // Driver running
	logic                permit_ff, nxt_permit;   // Segment writes allowed
	logic [3:0]          presc_ff, nxt_presc;     // Prescale down counter
	logic [3:0]          reload_ff, nxt_reload;   // Ratio in use
	lpp_pkg::lpp_drive_t drive_ff, nxt_drive;     // Registered drive
	logic                tick_ff, nxt_tick;       // Prescaled tick
	logic                fend_ff, nxt_fend;       // Frame boundary pulse
	// Decode helpers
	logic                wr_acc, rd_acc;          // Access phase strobes
	logic                hit_ctrl, hit_cfg, hit_seg;
	logic [1:0]          seg_idx;                 // Segment register index
	logic [1:0]          mux;                     // Multiplex select
	logic                tick_now, frame_now;     // Combinational events
	logic [31:0]         rd_word;                 // Read mux
	logic                seg_wr_ok;               // Segment write lands

	// Access phase strobes, zero wait states
	assign wr_acc   = psel && penable && pwrite;
	assign rd_acc   = psel && penable && !pwrite;
	assign hit_ctrl = (paddr == lpp_pkg::ADDR_CTRL);
	assign hit_cfg  = (paddr == lpp_pkg::ADDR_CFG);
	// Aligned words from the segment base up to the last segment register
	assign hit_seg  = (paddr[1:0] == 2'h0) && (paddr >= lpp_pkg::ADDR_SEG_BASE)
	                  && (paddr < 8'(lpp_pkg::ADDR_SEG_BASE + 4 * lpp_pkg::SEG_REGS));
	assign seg_idx  = 2'(paddr[3:2] - 2'h2);
	assign mux      = cfg_ff[lpp_pkg::MUX_LSB +: lpp_pkg::MUX_W];
	assign pready   = 1'b1;
	assign seg_wr_ok = wr_acc && hit_seg && permit_ff;

	// Read mux, unmapped answers error
	always_comb begin
		rd_word = 32'h0000_0000;
		pslverr = 1'b0;
		if (hit_ctrl) begin
			rd_word[7:0] = ctrl_ff;
			rd_word[lpp_pkg::BIT_DRV_ACTIVE] = active_ff;
			rd_word[lpp_pkg::BIT_SEG_PERMIT] = permit_ff;
		end else if (hit_cfg) begin
			rd_word[2:0] = cfg_ff[2:0];
		end else if (hit_seg) begin
			rd_word[7:0] = seg_ff[seg_idx];
		end else begin
			pslverr = psel && penable;
		end
	end
	assign prdata = rd_access_data(rd_acc, rd_word);

	// Read data only during a read access
	function automatic logic [31:0] rd_access_data(input logic en, input logic [31:0] w);
		rd_access_data = en ? w : 32'h0000_0000;
	endfunction

	// Software register next values
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_cfg  = cfg_ff;
		for (int i = 0; i < lpp_pkg::SEG_REGS; i++) begin
			nxt_seg[i] = seg_ff[i];
		end
		if (wr_acc && hit_ctrl) begin
			// Status bits are read only
			nxt_ctrl = pwdata[7:0];
			nxt_ctrl[lpp_pkg::BIT_DRV_ACTIVE] = 1'b0;
			nxt_ctrl[lpp_pkg::BIT_SEG_PERMIT] = 1'b0;
		end
		if (wr_acc && hit_cfg) begin
			nxt_cfg = {5'h00, pwdata[2:0]};
		end
		if (seg_wr_ok) begin
			nxt_seg[seg_idx] = pwdata[7:0];
		end
	end

	// Software register storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= lpp_pkg::RST_CTRL;
			cfg_ff  <= lpp_pkg::RST_CFG;
			for (int i = 0; i < lpp_pkg::SEG_REGS; i++) begin
				seg_ff[i] <= lpp_pkg::RST_SEG;
			end
		end else begin
			ctrl_ff <= nxt_ctrl;
			cfg_ff  <= nxt_cfg;
			for (int i = 0; i < lpp_pkg::SEG_REGS; i++) begin
				seg_ff[i] <= nxt_seg[i];
			end
		end
	end

	// Tick when the down counter expires
	assign tick_now  = active_ff && (presc_ff == 4'h0);
	// Frame ends on second phase of last common
	assign frame_now = tick_now && drive_ff.phase && (drive_ff.com_index == mux);

	// Engine next values
	always_comb begin
		nxt_active = active_ff;
		nxt_permit = permit_ff;
		nxt_presc  = presc_ff;
		nxt_reload = reload_ff;
		nxt_drive  = drive_ff;
		nxt_tick   = tick_now;
		nxt_fend   = frame_now;
		// Start at once, stop only on a frame boundary
		if (cfg_ff[lpp_pkg::BIT_DRV_ENABLE]) begin
			nxt_active = 1'b1;
		end else if (!active_ff || frame_now) begin
			nxt_active = 1'b0;
		end
		// Prescaler
		if (!active_ff) begin
			nxt_presc  = ctrl_ff[lpp_pkg::PRESC_LSB +: lpp_pkg::PRESC_W];
			nxt_reload = nxt_presc;
		end else if (presc_ff == 4'h0) begin
			nxt_presc  = ctrl_ff[lpp_pkg::PRESC_LSB +: lpp_pkg::PRESC_W];
			nxt_reload = nxt_presc;
		end else begin
			nxt_presc = 4'(presc_ff - 4'h1);
		end
		// Common sequencing and phase
		nxt_drive.type_b = ctrl_ff[lpp_pkg::BIT_WAVE_KIND];
		if (!active_ff) begin
			nxt_drive.com_index = 2'h0;
			nxt_drive.phase     = 1'b0;
		end else if (tick_now) begin
			nxt_drive.phase = !drive_ff.phase;
			if (drive_ff.phase) begin
				nxt_drive.com_index = frame_now ? 2'h0 : 2'(drive_ff.com_index + 2'h1);
			end
		end
		// Static bias when one common
		nxt_drive.bias_static = (mux == lpp_pkg::MUX_STATIC);
		nxt_drive.bias_half = ctrl_ff[lpp_pkg::BIT_BIAS_LEVEL]
		                      && (mux != lpp_pkg::MUX_STATIC)
		                      && (mux != lpp_pkg::MUX_QUAD);
		// Permit: idle, or new frame; set wins
		if (!active_ff || frame_now) begin
			nxt_permit = 1'b1;
		end else if (wr_acc && hit_seg) begin
			nxt_permit = 1'b0;
		end
	end

	// Engine storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_ff <= 1'b0;
			permit_ff <= 1'b1;
			presc_ff  <= 4'h0;
			reload_ff <= 4'h0;
			drive_ff  <= lpp_pkg::RST_DRIVE;
			tick_ff   <= 1'b0;
			fend_ff   <= 1'b0;
		end else begin
			active_ff <= nxt_active;
			permit_ff <= nxt_permit;
			presc_ff  <= nxt_presc;
			reload_ff <= nxt_reload;
			drive_ff  <= nxt_drive;
			tick_ff   <= nxt_tick;
			fend_ff   <= nxt_fend;
		end
	end

	// Frame-rate phase and the registered drive view
	logic                type_b_phase_ff, nxt_type_b_phase; // Frame-rate phase
	lpp_pkg::lpp_drive_t drive_out_ff, nxt_drive_out;      // Drive seen outside
	assign nxt_type_b_phase = !active_ff ? 1'b0 : (type_b_phase_ff ^ frame_now);
	always_comb begin
		nxt_drive_out = nxt_drive;
		if (nxt_drive.type_b) begin
			nxt_drive_out.phase = nxt_type_b_phase;
		end
	end
	// Drive output straight from flops, no glitching mux
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			type_b_phase_ff <= 1'b0;
			drive_out_ff    <= lpp_pkg::RST_DRIVE;
		end else begin
			type_b_phase_ff <= nxt_type_b_phase;
			drive_out_ff    <= nxt_drive_out;
		end
	end

	// Outputs
	assign drive     = drive_out_ff;
	assign lcd_tick  = tick_ff;
	assign frame_end = fend_ff;
	assign segment_pattern_regs = {seg_ff[3], seg_ff[2], seg_ff[1], seg_ff[0]};

	// Helper: cycles since last reload while active
	logic [4:0] gap_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_ff <= 5'h00;
		end else if (!active_ff || tick_now) begin
			gap_ff <= 5'h00;
		end else begin
			gap_ff <= 5'(gap_ff + 5'h01);
		end
	end

	property p_type_b_phase;
		@(posedge pclk) disable iff (!presetn)
		(drive_ff.type_b && $changed(type_b_phase_ff) && $past(active_ff)) |-> $past(frame_now);
	endproperty
	a_type_b_phase: assert property (p_type_b_phase) else $error("type-B phase moved off frame");

	property p_type_a_phase;
		@(posedge pclk) disable iff (!presetn)
		(active_ff && tick_now) |=> (drive_ff.phase != $past(drive_ff.phase)) || !active_ff;
	endproperty
	a_type_a_phase: assert property (p_type_a_phase) else $error("type-A phase missed tick");

	property p_bias_half;
		@(posedge pclk) disable iff (!presetn)
		(ctrl_ff[lpp_pkg::BIT_BIAS_LEVEL] && (mux == 2'h1 || mux == 2'h2)) |=> drive_ff.bias_half;
	endproperty
	a_bias_half: assert property (p_bias_half) else $error("half bias not applied");

	property p_bias_third;
		@(posedge pclk) disable iff (!presetn)
		(!ctrl_ff[lpp_pkg::BIT_BIAS_LEVEL] || mux == lpp_pkg::MUX_QUAD) |=> !drive_ff.bias_half;
	endproperty
	a_bias_third: assert property (p_bias_third) else $error("third bias not applied");

	property p_active_read;
		@(posedge pclk) disable iff (!presetn)
		(rd_acc && hit_ctrl) |-> (prdata[lpp_pkg::BIT_DRV_ACTIVE] == active_ff);
	endproperty
	a_active_read: assert property (p_active_read) else $error("active bit misread");

	property p_permit_read;
		@(posedge pclk) disable iff (!presetn)
		(rd_acc && hit_ctrl) |-> (prdata[lpp_pkg::BIT_SEG_PERMIT] == permit_ff);
	endproperty
	a_permit_read: assert property (p_permit_read) else $error("permit bit misread");

	property p_seg_block;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && hit_seg && !permit_ff) |=> $stable(segment_pattern_regs);
	endproperty
	a_seg_block: assert property (p_seg_block) else $error("blocked segment write landed");

	property p_presc_gap;
		@(posedge pclk) disable iff (!presetn)
		(tick_now && $past(active_ff)) |-> (gap_ff == {1'b0, reload_ff});
	endproperty
	a_presc_gap: assert property (p_presc_gap) else $error("prescale period wrong");

	property p_reserved;
		@(posedge pclk) disable iff (!presetn)
		rd_acc |-> (prdata[31:8] == 24'h000000);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

	property p_reload_hold;
		@(posedge pclk) disable iff (!presetn)
		(active_ff && presc_ff != 4'h0) |=> $stable(reload_ff);
	endproperty
	a_reload_hold: assert property (p_reload_hold) else $error("ratio changed mid count");

	c_frame: cover property (@(posedge pclk) disable iff (!presetn) frame_now);
	c_blocked: cover property (@(posedge pclk) disable iff (!presetn) wr_acc && hit_seg && !permit_ff);
	c_slow: cover property (@(posedge pclk) disable iff (!presetn) tick_now && reload_ff == 4'hf);
endmodule

// *** lcd_phase_prescale_control_tb_top.sv ***
module lcd_phase_prescale_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Clock, reset, bus
	logic                pclk = 1'b0;
	logic                presetn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [7:0]          paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	lpp_pkg::lpp_drive_t drive;
	logic                lcd_tick;
	logic                frame_end;
	logic [31:0]         segment_pattern_regs;
	// Bench state and behavioural model
	int                  err_total = 0;
	int                  cmp_count = 0;
	int                  cyc = 0;
	int                  last_tick = 0;
	int                  gap = 0;
	int                  ctrl_m;
	logic [7:0]          seg_m [4];
	logic [31:0]         seed = 32'h7175;
	logic [31:0]         rd;
	logic                err;
	logic [31:0]         exp_seg;
	logic                ph;
	int                  r;

	lpp_core u_lpp_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .drive(drive), .lcd_tick(lcd_tick), .frame_end(frame_end),
		.segment_pattern_regs(segment_pattern_regs));

	// Free clock, 10 ns period
	always #5 pclk = ~pclk;

	// Cycle count and gap between prescaler ticks
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (lcd_tick === 1'b1) begin
			gap <= cyc - last_tick;
			last_tick <= cyc;
		end
	end

	// Pseudo-random source
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Verdict and end of run
	task automatic end_sim();
		if (err_total == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Compare seen against expected
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer, waits for pready under a bound
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Let the landing edge settle before anyone looks at outputs
		#1;
		if (n >= 50) begin
			err_total++;
			end_sim();
		end
	endtask

	// Write with model update for the control register
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		if (a == lpp_pkg::ADDR_CTRL) begin
			ctrl_m = d[7:0];
		end
		apb(1'b1, a, d, q, e);
	endtask

	// Read of the control register against the model
	task automatic rd_ctrl(input logic act, input logic perm);
		logic [31:0] q;
		logic        e;
		apb(1'b0, lpp_pkg::ADDR_CTRL, 32'h0, q, e);
		chk(q, (ctrl_m & 32'hcf) | (act << 5) | (perm << 4));
	endtask

	// Wait for a tick (sel 0) or a frame end (sel 1)
	task automatic wait_ev(input logic sel);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((sel ? frame_end : lcd_tick) !== 1'b1 && n < 2000);
		#1;
		if (n >= 2000) begin
			err_total++;
			end_sim();
		end
	endtask

	// Segment image from the model
	function automatic logic [31:0] seg_img();
		return {seg_m[3], seg_m[2], seg_m[1], seg_m[0]};
	endfunction

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ctrl_m = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// Values after reset, driver idle
		rd_ctrl(1'b0, 1'b1);
		apb(1'b0, lpp_pkg::ADDR_CFG, 32'h0, rd, err);
		chk(rd, 32'h0);
		// Idle driver accepts every segment write
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			seg_m[i] = seed[7:0];
			wr(lpp_pkg::ADDR_SEG_BASE + 8'(4 * i), seed);
		end
		chk(segment_pattern_regs, seg_img());
		// Unmapped place refused
		apb(1'b1, 8'h40, 32'hffff_ffff, rd, err);
		chk(err, 1'b1);
		apb(1'b0, 8'h40, 32'h0, rd, err);
		chk(rd, 32'h0);
		// Status bits are read-only, upper bits dropped
		wr(lpp_pkg::ADDR_CTRL, 32'hffff_ff3f);
		ctrl_m = 8'h0f;
		rd_ctrl(1'b0, 1'b1);
		// Multiplex, bias and wave kind table, never the forbidden bias
		for (int m = 0; m < 4; m++) begin
			for (int b = 0; b < 2; b++) begin
				if (b == 0 || m == 1 || m == 2) begin
					wr(lpp_pkg::ADDR_CFG, 32'(m * 2 + 1));
					wr(lpp_pkg::ADDR_CTRL, 32'((m % 2) * 128 + b * 64));
					repeat (3) @(posedge pclk);
					#1;
					chk(drive.bias_half, b == 1 && (m == 1 || m == 2));
					chk(drive.bias_static, m == 0);
					chk(drive.type_b, m % 2);
					rd_ctrl(1'b1, 1'b1);
				end
			end
		end
		// Prescale ratios: low bound, random, high bound
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			r = (k == 0) ? 0 : (k == 1) ? int'(seed[3:0]) : 15;
			wr(lpp_pkg::ADDR_CTRL, 32'(r));
			wait_ev(1'b0);
			wait_ev(1'b0);
			wait_ev(1'b0);
			chk(gap, r + 1);
		end
		// Ratio change in mid-period waits for the reload
		wait_ev(1'b0);
		wr(lpp_pkg::ADDR_CTRL, 32'h0);
		wait_ev(1'b0);
		chk(gap, 16);
		wait_ev(1'b0);
		chk(gap, 1);
		// Write permit while running
		wr(lpp_pkg::ADDR_CTRL, 32'h0f);
		wait_ev(1'b1);
		chk(drive.com_index, 2'h0);
		chk(drive.phase, 1'b0);
		seg_m[0] = 8'h5a;
		wr(lpp_pkg::ADDR_SEG_BASE, 32'h5a);
		wr(lpp_pkg::ADDR_SEG_BASE + 8'h04, 32'ha5);
		chk(segment_pattern_regs, seg_img());
		rd_ctrl(1'b1, 1'b0);
		wait_ev(1'b1);
		rd_ctrl(1'b1, 1'b1);
		seg_m[1] = 8'hc3;
		wr(lpp_pkg::ADDR_SEG_BASE + 8'h04, 32'hc3);
		chk(segment_pattern_regs, seg_img());
		// Type-B phase holds within a frame and flips at its end
		wr(lpp_pkg::ADDR_CTRL, 32'h8f);
		wait_ev(1'b1);
		ph = drive.phase;
		wait_ev(1'b0);
		chk(drive.phase, ph);
		wait_ev(1'b1);
		chk(drive.phase, !ph);
		// Disable stops the driver at a frame end
		wr(lpp_pkg::ADDR_CFG, 32'h6);
		wait_ev(1'b1);
		repeat (2) @(posedge pclk);
		rd_ctrl(1'b0, 1'b1);
		end_sim();
	end
endmodule
